// File: design/skp_pkg.sv
// Constants, keyword dictionary and helper functions of the keyword parser.
package skp_pkg;

    // ----------------------------------------------------------------
    // Character codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_COLON = 8'h3a;
    localparam logic [7:0] CH_SEMI = 8'h3b;
    localparam logic [7:0] CH_QUERY = 8'h3f;
    localparam logic [7:0] CH_UP_A = 8'h41;
    localparam logic [7:0] CH_UP_Z = 8'h5a;
    localparam logic [7:0] CH_LO_A = 8'h61;
    localparam logic [7:0] CH_LO_Z = 8'h7a;
    localparam logic [7:0] CASE_MASK = 8'hdf;

    // ----------------------------------------------------------------
    // Keyword dictionary
    // ----------------------------------------------------------------
    localparam int NKW = 16;
    localparam int KW_IDX_W = 4;
    localparam logic [3:0] KW_MAX = 4'hc;
    localparam logic [3:0] SHORT_MAX = 4'h4;
    localparam logic [3:0] SHORT_VOWEL = 4'h3;
    localparam int VOWEL_POS = 8;

    // Entries are left justified: element 11 holds the first letter.
    localparam logic [NKW-1:0][11:0][7:0] KW_TEXT = {
        "LIST        ", "MODE        ", "SOURCE      ", "OUTPUT      ",
        "TRIGGER     ", "IMMEDIATE   ", "LEVEL       ", "EVENT       ",
        "ENABLE      ", "CONDITION   ", "QUESTIONABLE", "OPERATION   ",
        "STATUS      ", "MEASURE     ", "CURRENT     ", "VOLTAGE     "
    };
    localparam logic [NKW-1:0][3:0] KW_LEN = {
        4'h4, 4'h4, 4'h6, 4'h6, 4'h7, 4'h9, 4'h5, 4'h5,
        4'h6, 4'h9, 4'hc, 4'h9, 4'h6, 4'h7, 4'h7, 4'h7
    };

    typedef enum logic [1:0] {
        SKP_KEY, SKP_QUERY, SKP_PARAM, SKP_SKIP
    } skp_fsm_t;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic isVowel(input logic [7:0] c);
        return c == "A" || c == "E" || c == "I" || c == "O" || c == "U";
    endfunction

    function automatic logic [3:0] kwShortLen(input int k);
        logic [3:0] len;
        len = KW_LEN[k];
        if (len <= SHORT_MAX) begin
            return len;
        end
        return isVowel(KW_TEXT[k][VOWEL_POS]) ? SHORT_VOWEL : SHORT_MAX;
    endfunction

    // Bit 4 flags a hit, bits 3:0 give the lowest matching entry.
    function automatic logic [KW_IDX_W:0] kwHit(input logic [NKW-1:0] m,
                                                 input logic [3:0] cnt);
        logic [KW_IDX_W:0] r;
        r = '0;
        for (int k = NKW - 1; k >= 0; k--) begin
            if (m[k] && cnt != 4'h0 &&
                (cnt == KW_LEN[k] || cnt == kwShortLen(k))) begin
                r = {1'b1, KW_IDX_W'(k)};
            end
        end
        return r;
    endfunction

endpackage

// File: design/skp_param_buf.sv
// Parameter text buffer with registered read data.
`timescale 1ns/1ps
`default_nettype none
module skp_param_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic wrEn,
    input wire logic [$clog2(DEPTH)-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    input wire logic [$clog2(DEPTH)-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0] rdData;
    } skp_buf_t;

    skp_buf_t st_q;
    skp_buf_t st_d;

    always_comb begin
        st_d = st_q;
        if (wrEn) begin
            st_d.mem[wrAddr] = wrData;
        end
        st_d.rdData = st_q.mem[rdAddr];
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rdData = st_q.rdData;

endmodule // skp_param_buf
`default_nettype wire

// File: design/skp_parser.sv
// Character-level keyword parser for text program messages.
// Functional notes
// - A character with the end-of-line qualifier ends the message.
// - A unit may end in one parameter set off by a space.
// - Keywords match in long form or in their 3 or 4 letter short form.
// - Any other truncation of a keyword is reported as an error.
// - Keyword letters are matched without regard to case.
// - A colon between keywords moves one level down the hierarchy.
// - A colon opening a unit returns the position to the top level.
// - The line feed is a second terminator and ends the message like the qualifier.
// - Semicolons split units; after a valid unit the next unit keeps the previous level.
// - A question mark after the last keyword makes the unit a query.
`timescale 1ns/1ps
`default_nettype none
module skp_parser #(
    parameter int MAX_DEPTH = 4,
    parameter int PARAM_DEPTH = 32
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic chValid,
    input wire logic [7:0] chData,
    input wire logic chEol,
    input wire logic errClr,
    input wire logic [$clog2(PARAM_DEPTH)-1:0] paramRdAddr,
    output logic unitValid,
    output logic [MAX_DEPTH*skp_pkg::KW_IDX_W-1:0] unitPath,
    output logic [$clog2(MAX_DEPTH+1)-1:0] unitDepth,
    output logic unitQuery,
    output logic [$clog2(PARAM_DEPTH+1)-1:0] unitParamLen,
    output logic [7:0] paramRdData,
    output logic parseErr
);

    localparam int DW = $clog2(MAX_DEPTH + 1);
    localparam int PW = $clog2(PARAM_DEPTH + 1);
    localparam int AW = $clog2(PARAM_DEPTH);
    localparam int NKW = skp_pkg::NKW;

    typedef struct packed {
        skp_pkg::skp_fsm_t fsm;
        logic [NKW-1:0] match;
        logic [3:0] cnt;
        logic [DW-1:0] depth;
        logic [MAX_DEPTH-1:0][skp_pkg::KW_IDX_W-1:0] path;
        logic unitStart;
        logic query;
        logic [PW-1:0] paramLen;
        logic err;
        logic outValid;
        logic [MAX_DEPTH-1:0][skp_pkg::KW_IDX_W-1:0] outPath;
        logic [DW-1:0] outDepth;
        logic outQuery;
        logic [PW-1:0] outParamLen;
    } skp_state_t;

    skp_state_t st_q;
    skp_state_t st_d;
    logic [7:0] chUp;
    logic isLetter;
    logic [3:0] kwPos;
    logic [NKW-1:0] charEq;
    logic pWr;
    logic errSet;
    logic wasSkip;

    // ----------------------------------------------------------------
    // Character classification
    // ----------------------------------------------------------------
    // Folding to upper case before the compare keeps one dictionary copy.
    assign isLetter = (chData >= skp_pkg::CH_UP_A &&
                       chData <= skp_pkg::CH_UP_Z) ||
                      (chData >= skp_pkg::CH_LO_A &&
                       chData <= skp_pkg::CH_LO_Z);
    assign chUp = isLetter ? (chData & skp_pkg::CASE_MASK) : chData;
    assign kwPos = skp_pkg::KW_MAX - 4'h1 - st_q.cnt;

    for (genvar k = 0; k < NKW; k++) begin : g_cmp
        assign charEq[k] = (st_q.cnt < skp_pkg::KW_LEN[k]) &&
                           (skp_pkg::KW_TEXT[k][kwPos] == chUp);
    end

    // ----------------------------------------------------------------
    // Unit helpers
    // ----------------------------------------------------------------
    function automatic skp_state_t pushKw(input skp_state_t s);
        skp_state_t r;
        logic [skp_pkg::KW_IDX_W:0] h;
        r = s;
        h = skp_pkg::kwHit(s.match, s.cnt);
        if (!h[skp_pkg::KW_IDX_W] || s.depth == DW'(MAX_DEPTH)) begin
            r.fsm = skp_pkg::SKP_SKIP;
        end else begin
            r.path[s.depth] = h[skp_pkg::KW_IDX_W-1:0];
            r.depth = s.depth + DW'(1);
            r.cnt = '0;
            r.match = '1;
            r.unitStart = 1'b0;
        end
        return r;
    endfunction

    function automatic skp_state_t emitUnit(input skp_state_t s);
        skp_state_t r;
        r = s;
        r.outValid = 1'b1;
        r.outPath = s.path;
        r.outDepth = s.depth;
        r.outQuery = s.query;
        r.outParamLen = s.paramLen;
        // The next unit continues under the parent of the last keyword.
        r.depth = s.depth - DW'(1);
        r.fsm = skp_pkg::SKP_KEY;
        r.unitStart = 1'b1;
        r.query = 1'b0;
        r.paramLen = '0;
        r.cnt = '0;
        r.match = '1;
        return r;
    endfunction

    // This starts a fresh unit at the top level.
    function automatic skp_state_t restart(input skp_state_t s);
        skp_state_t r;
        r = s;
        r.fsm = skp_pkg::SKP_KEY;
        r.unitStart = 1'b1;
        r.depth = '0;
        r.cnt = '0;
        r.match = '1;
        r.query = 1'b0;
        r.paramLen = '0;
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.outValid = 1'b0;
        pWr = 1'b0;
        errSet = 1'b0;
        wasSkip = 1'b0;
        if (chValid) begin
            if (chData != skp_pkg::CH_LF) begin
                unique case (st_q.fsm)
                    skp_pkg::SKP_KEY: begin
                        if (isLetter) begin
                            if (st_q.cnt == skp_pkg::KW_MAX) begin
                                st_d.fsm = skp_pkg::SKP_SKIP;
                            end else begin
                                st_d.match = st_q.match & charEq;
                                st_d.cnt = st_q.cnt + 4'h1;
                            end
                        end else if (chData == skp_pkg::CH_COLON) begin
                            if (st_q.cnt != 4'h0) begin
                                st_d = pushKw(st_q);
                            end else if (st_q.unitStart) begin
                                st_d.depth = '0;
                                st_d.unitStart = 1'b0;
                            end else begin
                                st_d.fsm = skp_pkg::SKP_SKIP;
                            end
                        end else if (chData == skp_pkg::CH_QUERY) begin
                            st_d = pushKw(st_q);
                            if (st_d.fsm != skp_pkg::SKP_SKIP) begin
                                st_d.fsm = skp_pkg::SKP_QUERY;
                                st_d.query = 1'b1;
                            end
                        end else if (chData == skp_pkg::CH_SPACE) begin
                            if (st_q.cnt != 4'h0 || !st_q.unitStart) begin
                                st_d = pushKw(st_q);
                                if (st_d.fsm != skp_pkg::SKP_SKIP) begin
                                    st_d.fsm = skp_pkg::SKP_PARAM;
                                end
                            end
                        end else if (chData == skp_pkg::CH_SEMI) begin
                            st_d = pushKw(st_q);
                            if (st_d.fsm != skp_pkg::SKP_SKIP) begin
                                st_d = emitUnit(st_d);
                            end else begin
                                // The separator that ends a bad unit is
                                // also where the next unit starts.
                                errSet = 1'b1;
                                st_d = restart(st_d);
                            end
                        end else begin
                            st_d.fsm = skp_pkg::SKP_SKIP;
                        end
                    end
                    skp_pkg::SKP_QUERY: begin
                        if (chData == skp_pkg::CH_SPACE) begin
                            st_d.fsm = skp_pkg::SKP_PARAM;
                        end else if (chData == skp_pkg::CH_SEMI) begin
                            st_d = emitUnit(st_q);
                        end else begin
                            st_d.fsm = skp_pkg::SKP_SKIP;
                        end
                    end
                    skp_pkg::SKP_PARAM: begin
                        if (chData == skp_pkg::CH_SEMI) begin
                            st_d = emitUnit(st_q);
                        end else if (st_q.paramLen == PW'(PARAM_DEPTH)) begin
                            st_d.fsm = skp_pkg::SKP_SKIP;
                        end else begin
                            pWr = 1'b1;
                            st_d.paramLen = st_q.paramLen + PW'(1);
                        end
                    end
                    skp_pkg::SKP_SKIP: begin
                        if (chData == skp_pkg::CH_SEMI) begin
                            st_d = restart(st_d);
                        end
                    end
                endcase
                errSet = errSet || (st_d.fsm == skp_pkg::SKP_SKIP &&
                                    st_q.fsm != skp_pkg::SKP_SKIP);
            end
            // A qualified character is consumed first and then ends the
            // message, so the last letter of a keyword may carry it.
            if (chData == skp_pkg::CH_LF || chEol) begin
                wasSkip = st_d.fsm == skp_pkg::SKP_SKIP;
                unique case (st_d.fsm)
                    skp_pkg::SKP_KEY: begin
                        if (st_d.cnt != 4'h0) begin
                            st_d = pushKw(st_d);
                            if (st_d.fsm != skp_pkg::SKP_SKIP) begin
                                st_d = emitUnit(st_d);
                            end
                        end else if (!st_d.unitStart) begin
                            st_d.fsm = skp_pkg::SKP_SKIP;
                        end
                    end
                    skp_pkg::SKP_QUERY, skp_pkg::SKP_PARAM: begin
                        st_d = emitUnit(st_d);
                    end
                    skp_pkg::SKP_SKIP: begin
                    end
                endcase
                if (st_d.fsm == skp_pkg::SKP_SKIP && !wasSkip) begin
                    errSet = 1'b1;
                end
                st_d = restart(st_d);
            end
        end
        // A new error outranks a clear in the same cycle.
        st_d.err = errSet || (st_q.err && !errClr);
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0;
            st_q.match <= '1;
            st_q.unitStart <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // The buffer is rewritten by the next unit, so parameter text must be
    // read before the following unit writes its first parameter byte.
    skp_param_buf #(
        .WIDTH(8),
        .DEPTH(PARAM_DEPTH)
    ) u_buf (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .wrEn(pWr),
        .wrAddr(st_q.paramLen[AW-1:0]),
        .wrData(chData),
        .rdAddr(paramRdAddr),
        .rdData(paramRdData)
    );

    assign unitValid = st_q.outValid;
    assign unitPath = st_q.outPath;
    assign unitDepth = st_q.outDepth;
    assign unitQuery = st_q.outQuery;
    assign unitParamLen = st_q.outParamLen;
    assign parseErr = st_q.err;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    logic [skp_pkg::KW_IDX_W:0] hitVec;
    logic hitAny;
    logic inKey;
    assign hitVec = skp_pkg::kwHit(st_q.match, st_q.cnt);
    assign hitAny = hitVec[skp_pkg::KW_IDX_W];
    assign inKey = chValid && !chEol && st_q.fsm == skp_pkg::SKP_KEY;

    property p_eolEnds;
        chValid && chEol |=> st_q.depth == '0 && st_q.unitStart &&
                             st_q.fsm == skp_pkg::SKP_KEY;
    endproperty
    a_eolEnds: assert property (p_eolEnds)
        else $error("eol character did not end the message");

    property p_lfEnds;
        chValid && chData == skp_pkg::CH_LF |=> st_q.depth == '0 &&
            st_q.fsm == skp_pkg::SKP_KEY && st_q.paramLen == '0;
    endproperty
    a_lfEnds: assert property (p_lfEnds)
        else $error("line feed did not return to the root");

    property p_validPulse;
        unitValid |=> !unitValid;
    endproperty
    a_validPulse: assert property (p_validPulse)
        else $error("unit valid held longer than one cycle");

    property p_query;
        inKey && chData == skp_pkg::CH_QUERY && hitAny &&
            st_q.depth != DW'(MAX_DEPTH)
            |=> st_q.query && st_q.fsm == skp_pkg::SKP_QUERY;
    endproperty
    a_query: assert property (p_query)
        else $error("question mark did not mark a query");

    property p_badAbbrev;
        inKey && chData == skp_pkg::CH_COLON && st_q.cnt != 4'h0 && !hitAny
            |=> parseErr && st_q.fsm == skp_pkg::SKP_SKIP;
    endproperty
    a_badAbbrev: assert property (p_badAbbrev)
        else $error("malformed keyword not flagged");

    property p_semiResync;
        inKey && chData == skp_pkg::CH_SEMI && !hitAny
            |=> parseErr && st_q.fsm == skp_pkg::SKP_KEY &&
                st_q.unitStart && st_q.depth == '0 && !unitValid;
    endproperty
    a_semiResync: assert property (p_semiResync)
        else $error("bad unit did not resync at its semicolon");

    property p_descend;
        inKey && chData == skp_pkg::CH_COLON && hitAny &&
            st_q.depth != DW'(MAX_DEPTH)
            |=> st_q.depth == $past(st_q.depth) + DW'(1) && !unitValid;
    endproperty
    a_descend: assert property (p_descend)
        else $error("keyword separator did not descend one level");

    property p_root;
        inKey && chData == skp_pkg::CH_COLON && st_q.cnt == 4'h0 &&
            st_q.unitStart |=> st_q.depth == '0 && !st_q.unitStart;
    endproperty
    a_root: assert property (p_root)
        else $error("root specifier did not return to the top");

    property p_keepLevel;
        inKey && chData == skp_pkg::CH_SEMI && hitAny &&
            st_q.depth != DW'(MAX_DEPTH)
            |=> unitValid && st_q.depth == $past(st_q.depth) &&
                unitDepth == st_q.depth + DW'(1);
    endproperty
    a_keepLevel: assert property (p_keepLevel)
        else $error("semicolon did not keep the unit level");

    property p_param;
        inKey && chData == skp_pkg::CH_SPACE && hitAny &&
            st_q.depth != DW'(MAX_DEPTH) |=> st_q.fsm == skp_pkg::SKP_PARAM;
    endproperty
    a_param: assert property (p_param)
        else $error("space after keyword did not open the parameter");

    property p_sticky;
        parseErr && !errClr |=> parseErr;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("error flag dropped without a clear");

    property p_skip;
        chValid && !chEol && st_q.fsm == skp_pkg::SKP_SKIP &&
            chData != skp_pkg::CH_SEMI && chData != skp_pkg::CH_LF
            |=> st_q.fsm == skp_pkg::SKP_SKIP && !unitValid;
    endproperty
    a_skip: assert property (p_skip)
        else $error("parser left discard before a separator");

    c_query: cover property (unitValid && unitQuery);
    c_param: cover property (unitValid && unitParamLen != '0);
    c_error: cover property (!parseErr ##1 parseErr);
    c_deep: cover property (unitValid && unitDepth == DW'(3));

endmodule // skp_parser
`default_nettype wire

// File: verification/skp_host.sv
// Host model that streams command text into the parser.
`timescale 1ns/1ps
`default_nettype none
module skp_host (
    input wire logic clk_sys,
    output logic chValid,
    output logic [7:0] chData,
    output logic chEol
);
    initial begin
        chValid = 1'b0;
        chData = 8'h00;
        chEol = 1'b0;
    end

    // ------------------------------------------------------------
    // Character stream
    // ------------------------------------------------------------
    // Text goes out unchanged, one character a cycle, back to back.
    // The caller composes paths, colons, semicolons and spaces.
    task automatic send(input string s, input bit eolLast);
        for (int i = 0; i < s.len(); i++) begin
            @(posedge clk_sys);
            #1;
            chValid = 1'b1;
            chData = s[i];
            chEol = eolLast && (i == s.len() - 1);
        end
        @(posedge clk_sys);
        #1;
        // Idle data is inverted so a stale byte is never read as valid.
        chValid = 1'b0;
        chData = ~chData;
        chEol = 1'b0;
    endtask
endmodule // skp_host
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking testbench of the keyword parser.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys;
    logic sys_rst;
    logic chValid;
    logic [7:0] chData;
    logic chEol;
    logic errClr;
    logic [4:0] paramRdAddr;
    logic unitValid;
    logic [15:0] unitPath;
    logic [2:0] unitDepth;
    logic unitQuery;
    logic [5:0] unitParamLen;
    logic [7:0] paramRdData;
    logic parseErr;
    int bad_count = 0;
    int total_checks = 0;
    int unitCount = 0;

    skp_host u_host (.clk_sys(clk_sys), .chValid(chValid),
        .chData(chData), .chEol(chEol));

    skp_parser #(.MAX_DEPTH(4), .PARAM_DEPTH(32)) u_dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .chValid(chValid),
        .chData(chData), .chEol(chEol), .errClr(errClr),
        .paramRdAddr(paramRdAddr), .unitValid(unitValid),
        .unitPath(unitPath), .unitDepth(unitDepth),
        .unitQuery(unitQuery), .unitParamLen(unitParamLen),
        .paramRdData(paramRdData), .parseErr(parseErr));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // A pulse that stood two cycles would be counted twice.
    always @(posedge clk_sys) begin
        if (unitValid === 1'b1) begin
            unitCount++;
        end
    end

    // ------------------------------------------------------------
    // Compare and report
    // ------------------------------------------------------------
    task automatic chkVal(input string what, input logic [15:0] exp,
                          input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic results();
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic waitUnit(input int n);
        int i;
        for (i = 0; i < 40 && unitCount < n; i++) begin
            @(posedge clk_sys);
            #1;
        end
        if (unitCount < n) begin
            bad_count++;
            $display("BAD unit wait expected %0d seen %0d", n, unitCount);
            results();
        end
    endtask

    // Levels above the reported depth are stale and masked off.
    task automatic checkUnit(input int n, input logic [2:0] depth,
                             input logic [15:0] path, input logic query,
                             input logic [5:0] len);
        logic [15:0] mask;
        waitUnit(n);
        mask = (16'h0001 << (4 * depth)) - 16'h0001;
        chkVal("unit count", 16'(n), 16'(unitCount));
        chkVal("depth", 16'(depth), 16'(unitDepth));
        chkVal("path", path, unitPath & mask);
        chkVal("query", 16'(query), 16'(unitQuery));
        chkVal("param length", 16'(len), 16'(unitParamLen));
    endtask

    task automatic clearErr();
        @(posedge clk_sys);
        #1;
        errClr = 1'b1;
        @(posedge clk_sys);
        #1;
        errClr = 1'b0;
        @(posedge clk_sys);
        #1;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic sQuery();
        u_host.send("VOLT?\n", 1'b0);
        checkUnit(1, 3'h1, 16'h0000, 1'b1, 6'h00);
    endtask

    task automatic sMixedCase();
        u_host.send("vOlTaGe 5\n", 1'b0);
        checkUnit(2, 3'h1, 16'h0000, 1'b0, 6'h01);
        paramRdAddr = 5'h00;
        repeat (2) @(posedge clk_sys);
        #1;
        chkVal("param byte", 16'h0035, 16'(paramRdData));
    endtask

    task automatic sLevels();
        u_host.send("STAT:OPER?;ENAB 16\n", 1'b0);
        checkUnit(4, 3'h2, 16'h0073, 1'b0, 6'h02);
    endtask

    task automatic sRoot();
        u_host.send("VOLT:LEV 6;:CURR:LEV 15\n", 1'b0);
        checkUnit(6, 3'h2, 16'h0091, 1'b0, 6'h02);
        paramRdAddr = 5'h01;
        repeat (2) @(posedge clk_sys);
        #1;
        chkVal("param byte", 16'h0035, 16'(paramRdData));
    endtask

    task automatic sEol();
        u_host.send("trig", 1'b1);
        checkUnit(7, 3'h1, 16'h000b, 1'b0, 6'h00);
    endtask

    task automatic sBadShort();
        u_host.send("IMME\n", 1'b0);
        repeat (3) @(posedge clk_sys);
        #1;
        chkVal("unit count", 16'h0007, 16'(unitCount));
        chkVal("error flag", 16'h0001, 16'(parseErr));
        clearErr();
        chkVal("error flag", 16'h0000, 16'(parseErr));
        u_host.send("ENABL;MODE\n", 1'b0);
        checkUnit(8, 3'h1, 16'h000e, 1'b0, 6'h00);
        chkVal("error flag", 16'h0001, 16'(parseErr));
        clearErr();
        chkVal("error flag", 16'h0000, 16'(parseErr));
    endtask

    initial begin
        sys_rst = 1'b1;
        errClr = 1'b0;
        paramRdAddr = 5'h00;
        repeat (5) @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        chkVal("error flag", 16'h0000, 16'(parseErr));
        sQuery();
        sMixedCase();
        sLevels();
        sRoot();
        sEol();
        sBadShort();
        results();
    end
endmodule // tb_top
`default_nettype wire
